// [logic/ofg_pkg.sv]
// shared constants and types of the optical front end gain and drive registers
package ofg_pkg;

  // ==========================================================
  // serial frame layout
  localparam int ADDR_W = 8;
  localparam int DATA_W = 24;
  localparam logic [4:0] ADDR_LAST_BIT = 5'h07;
  localparam logic [4:0] FRAME_LAST_BIT = 5'h1F;

  // ==========================================================
  // register map and reset values
  localparam logic [7:0] ADDR_READ_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RX_GAIN = 8'h21;
  localparam logic [7:0] ADDR_LED_CTRL = 8'h22;
  localparam logic [23:0] RST_RX_GAIN = 24'h000000;
  localparam logic [23:0] RST_LED_CTRL = 24'h000000;
  localparam logic RST_READ_EN = 1'h0;
  localparam int READ_EN_BIT = 0;
  // writable bits; reserved bits are stored and read as zero
  localparam logic [23:0] RX_GAIN_WMASK = 24'h0F47FF;
  localparam logic [23:0] LED_CTRL_WMASK = 24'h03FFFF;

  // ==========================================================
  // field positions
  localparam int AMB_LSB = 16;
  localparam int S2EN_BIT = 14;
  localparam int GAIN_LSB = 8;
  localparam int CAP_LSB = 3;
  localparam int RES_LSB = 0;
  localparam int RANGE_LSB = 16;
  localparam int DRVA_LSB = 8;
  localparam int DRVB_LSB = 0;

  // ==========================================================
  // field codes
  localparam logic [3:0] AMB_MAX_CODE = 4'hA;
  localparam logic [2:0] GAIN_MAX_CODE = 3'h4;
  localparam logic [2:0] RES_NONE_CODE = 3'h7;
  localparam logic [1:0] RANGE_ALT = 2'h1;
  localparam logic [1:0] RANGE_OFF = 2'h3;
  localparam logic [1:0] TXREF_0P25 = 2'h0;
  localparam logic [1:0] TXREF_0P5 = 2'h1;
  localparam logic [1:0] TXREF_1P0 = 2'h2;
  localparam logic [1:0] TXREF_0P75 = 2'h3;

  // capacitance in pF: base plus one weight per select bit
  localparam logic [7:0] CAP_BASE_PF = 8'h05;
  localparam logic [7:0] CAP_W0_PF = 8'h05;
  localparam logic [7:0] CAP_W1_PF = 8'h0F;
  localparam logic [7:0] CAP_W2_PF = 8'h19;
  localparam logic [7:0] CAP_W3_PF = 8'h32;
  localparam logic [7:0] CAP_W4_PF = 8'h96;

  // full-scale drive currents in mA
  localparam logic [6:0] FS_0_MA = 7'h00;
  localparam logic [6:0] FS_25_MA = 7'h19;
  localparam logic [6:0] FS_50_MA = 7'h32;
  localparam logic [6:0] FS_75_MA = 7'h4B;
  localparam logic [6:0] FS_100_MA = 7'h64;

  // ==========================================================
  // serial port phases
  typedef enum logic [1:0] {
    OFG_IDLE = 2'b00,
    OFG_ADDR = 2'b01,
    OFG_DATA = 2'b10,
    OFG_DONE = 2'b11
  } ofg_phase_t;

endpackage

// [logic/ofg_reg_if.sv]
// access channel from the serial port to the register file
`timescale 1ns/1ns
interface ofg_reg_if;
  import ofg_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] rdata;

  modport port (output addr, output wdata, output wr, output rd,
    input rdata);
  modport regs (input addr, input wdata, input wr, input rd,
    output rdata);
endinterface

// [logic/ofg_spi_port.sv]
// serial register port: 8 address bits then 24 data bits, msb first
`timescale 1ns/1ns
module ofg_spi_port
  import ofg_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_n_o,
  ofg_reg_if.port bus
);

  // ==========================================================
  // edge detection on the serial clock
  logic sclk_q_r;
  logic rise;
  logic fall;
  ofg_phase_t phase_r;
  logic [4:0] bit_cnt_r;
  logic [DATA_W-1:0] shin_r;
  logic [DATA_W-1:0] shout_r;
  logic [DATA_W-1:0] shin_nxt;

  // pins are synchronous, so the previous sample is a clean reference
  assign rise = spi_sclk_i & ~sclk_q_r & ~spi_cs_n_i;
  assign fall = ~spi_sclk_i & sclk_q_r & ~spi_cs_n_i;
  assign shin_nxt = {shin_r[DATA_W-2:0], spi_mosi_i};

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_q_r <= 1'b0;
    end else if (ce_i) begin
      sclk_q_r <= spi_sclk_i;
    end
  end

  // ==========================================================
  // frame phase and bit count; select high aborts any frame
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_r <= OFG_IDLE;
      bit_cnt_r <= 5'h00;
      shin_r <= '0;
    end else if (ce_i) begin
      if (spi_cs_n_i) begin
        phase_r <= OFG_IDLE;
        bit_cnt_r <= 5'h00;
      end else if (phase_r == OFG_IDLE) begin
        phase_r <= OFG_ADDR;
      end else if (rise && phase_r != OFG_DONE) begin
        shin_r <= shin_nxt;
        bit_cnt_r <= bit_cnt_r + 5'h01;
        if (bit_cnt_r == ADDR_LAST_BIT) begin
          phase_r <= OFG_DATA;
        end
        if (bit_cnt_r == FRAME_LAST_BIT) begin
          phase_r <= OFG_DONE; // extra clocks are ignored
        end
      end
    end
  end

  // ==========================================================
  // address and write strobes toward the register file
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus.addr <= '0;
      bus.wdata <= '0;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
    end else if (ce_i) begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      if (rise && phase_r == OFG_ADDR && bit_cnt_r == ADDR_LAST_BIT) begin
        bus.addr <= shin_nxt[ADDR_W-1:0];
        bus.rd <= 1'b1;
      end
      if (rise && phase_r == OFG_DATA && bit_cnt_r == FRAME_LAST_BIT) begin
        bus.wdata <= shin_nxt;
        bus.wr <= 1'b1;
      end
    end
  end

  // ==========================================================
  // read data leave on falling edges so the host samples on rising
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shout_r <= '0;
      spi_miso_o <= 1'b0;
      spi_miso_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      spi_miso_oe_n_o <= spi_cs_n_i;
      if (spi_cs_n_i) begin
        spi_miso_o <= 1'b0;
      end else if (fall && phase_r == OFG_DATA) begin
        if (bit_cnt_r == ADDR_LAST_BIT + 5'h01) begin
          spi_miso_o <= bus.rdata[DATA_W-1];
          shout_r <= {bus.rdata[DATA_W-2:0], 1'b0};
        end else begin
          spi_miso_o <= shout_r[DATA_W-1];
          shout_r <= {shout_r[DATA_W-2:0], 1'b0};
        end
      end
    end
  end

endmodule

// [logic/ofg_regs.sv]
// receive gain and LED drive configuration registers with decoded settings
`timescale 1ns/1ns

// What this block does
// - ambient cancellation code 0 to 10 gives 0 to 10 uA, resets to 0.
// - bit 14 bypasses the second gain stage at 0 and applies it at 1.
// - gain codes 0 to 4 select 0, 3.5, 6, 9.5, 12 dB; 5 to 7 reserved.
// - capacitor code 0 gives 5 pF; single bits add 5, 15, 25, 50, 150 pF.
// - several capacitor bits may be set and their values add up.
// - resistor codes 0 to 5 pick 500k down to 10k ohm, code 6 picks 1M and code 7 picks none.
// - range bits 17:16 set the full-scale current for both LEDs.
// - first LED code in bits 15:8 resets to 00h and scales the current.
// - second LED code in bits 7:0 resets to 00h and scales the current.
// - LED register holds range, first and second code; 23:18 are zero.
// - range 00 and 10 act alike, 01 is the alternate scale, 11 is off.
// - each LED current is its code over 256 times the full-scale value.
// - the receive gain register sits at 21h and resets to all zeros.
module ofg_regs
  import ofg_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  input wire logic [1:0] tx_ref_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_n_o,
  output logic [3:0] ambient_cancel_current_code_o,
  output logic [3:0] ambient_ua_o,
  output logic ambient_reserved_o,
  output logic second_stage_enable_b_o,
  output logic [2:0] second_stage_gain_b_o,
  output logic [6:0] stage_gain_tenth_db_o,
  output logic gain_reserved_o,
  output logic [4:0] feedback_cap_select_o,
  output logic [7:0] feedback_cap_pf_o,
  output logic [2:0] feedback_res_select_o,
  output logic [9:0] feedback_res_kohm_o,
  output logic feedback_res_none_o,
  output logic [1:0] drive_fullscale_range_o,
  output logic drive_alt_scale_o,
  output logic tx_off_o,
  output logic [6:0] fullscale_ma_o,
  output logic [7:0] drive_current_a_o,
  output logic [7:0] drive_current_b_o,
  output logic [14:0] drive_a_x256_ma_o,
  output logic [14:0] drive_b_x256_ma_o
);

  // ==========================================================
  // decode helpers
  // total feedback capacitance: every set bit adds its own weight
  function automatic logic [7:0] cap_pf(input logic [4:0] sel);
    logic [7:0] sum;
    sum = CAP_BASE_PF;
    if (sel[0]) sum = sum + CAP_W0_PF;
    if (sel[1]) sum = sum + CAP_W1_PF;
    if (sel[2]) sum = sum + CAP_W2_PF;
    if (sel[3]) sum = sum + CAP_W3_PF;
    if (sel[4]) sum = sum + CAP_W4_PF;
    return sum;
  endfunction

  // feedback resistance in kohm; the none code reports zero
  function automatic logic [9:0] res_kohm(input logic [2:0] sel);
    logic [9:0] r;
    unique case (sel)
      3'h0: r = 10'h1F4;
      3'h1: r = 10'h0FA;
      3'h2: r = 10'h064;
      3'h3: r = 10'h032;
      3'h4: r = 10'h019;
      3'h5: r = 10'h00A;
      3'h6: r = 10'h3E8;
      3'h7: r = 10'h000;
    endcase
    return r;
  endfunction

  // stage gain in tenths of a dB; reserved codes fall back to unity
  function automatic logic [6:0] gain_tdb(input logic [2:0] sel);
    logic [6:0] g;
    unique case (sel)
      3'h0: g = 7'h00;
      3'h1: g = 7'h23;
      3'h2: g = 7'h3C;
      3'h3: g = 7'h5F;
      3'h4: g = 7'h78;
      default: g = 7'h00;
    endcase
    return g;
  endfunction

  // full-scale current from range and the reference level outside;
  // settings marked unusable report zero rather than guessing a value
  function automatic logic [6:0] fullscale(input logic [1:0] rng,
                                           input logic [1:0] ref_sel);
    logic [6:0] fs;
    fs = FS_0_MA;
    if (rng == RANGE_ALT) begin
      unique case (ref_sel)
        TXREF_0P25: fs = FS_25_MA;
        TXREF_0P5: fs = FS_50_MA;
        TXREF_0P75: fs = FS_75_MA;
        TXREF_1P0: fs = FS_100_MA;
      endcase
    end else if (rng != RANGE_OFF) begin
      if (ref_sel == TXREF_0P25) fs = FS_50_MA;
      if (ref_sel == TXREF_0P5) fs = FS_100_MA;
    end
    return fs;
  endfunction

  // code times full scale; the divide by 256 is left to the reader
  function automatic logic [14:0] scale(input logic [7:0] code,
                                        input logic [6:0] fs);
    return 15'(code) * 15'(fs);
  endfunction

  // ==========================================================
  // storage and serial port
  ofg_reg_if rif ();
  logic [DATA_W-1:0] rx_gain_r;
  logic [DATA_W-1:0] led_ctrl_r;
  logic read_en_r;
  logic [DATA_W-1:0] rdata_r;
  logic wr_ok;

  ofg_spi_port u_port (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .spi_cs_n_i(spi_cs_n_i),
    .spi_sclk_i(spi_sclk_i),
    .spi_mosi_i(spi_mosi_i),
    .spi_miso_o(spi_miso_o),
    .spi_miso_oe_n_o(spi_miso_oe_n_o),
    .bus(rif.port)
  );

  // read mode is a global switch: while it is set, every data
  // write is dropped without any sign to the host
  // in read mode frames to data registers only read, never write
  assign wr_ok = rif.wr & ~read_en_r;

  // read mode is always writable so the host can leave it again
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      read_en_r <= RST_READ_EN;
    end else if (ce_i && rif.wr && rif.addr == ADDR_READ_CTRL) begin
      read_en_r <= rif.wdata[READ_EN_BIT];
    end
  end

  // receive gain register; reserved bits are forced to zero
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_gain_r <= RST_RX_GAIN;
    end else if (ce_i && wr_ok && rif.addr == ADDR_RX_GAIN) begin
      rx_gain_r <= rif.wdata & RX_GAIN_WMASK;
    end
  end

  // LED control register; bits 23:18 never store a one
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      led_ctrl_r <= RST_LED_CTRL;
    end else if (ce_i && wr_ok && rif.addr == ADDR_LED_CTRL) begin
      led_ctrl_r <= rif.wdata & LED_CTRL_WMASK;
    end
  end

  // capturing right after the address byte has the first bit ready
  // at the next falling serial clock, with no turnaround bit
  // read data latched once per frame after the address arrives;
  // reading changes nothing, and unmapped addresses return zero
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= '0;
    end else if (ce_i && rif.rd) begin
      if (!read_en_r) begin
        rdata_r <= '0;
      end else if (rif.addr == ADDR_RX_GAIN) begin
        rdata_r <= rx_gain_r;
      end else if (rif.addr == ADDR_LED_CTRL) begin
        rdata_r <= led_ctrl_r;
      end else begin
        rdata_r <= '0;
      end
    end
  end
  assign rif.rdata = rdata_r;

  // ==========================================================
  // receive chain settings
  logic [3:0] amb_code;
  logic [2:0] gain_code;
  logic [4:0] cap_code;
  logic [2:0] res_code;
  assign amb_code = rx_gain_r[AMB_LSB +: 4];
  assign gain_code = rx_gain_r[GAIN_LSB +: 3];
  assign cap_code = rx_gain_r[CAP_LSB +: 5];
  assign res_code = rx_gain_r[RES_LSB +: 3];

  // decoded outputs lag the stored fields by one clock
  // ambient current: linear in uA; reserved codes cancel nothing
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ambient_cancel_current_code_o <= 4'h0;
      ambient_ua_o <= 4'h0;
      ambient_reserved_o <= 1'b0;
    end else if (ce_i) begin
      ambient_cancel_current_code_o <= amb_code;
      ambient_reserved_o <= amb_code > AMB_MAX_CODE;
      ambient_ua_o <= (amb_code > AMB_MAX_CODE) ? 4'h0 : amb_code;
    end
  end

  // bypass reports zero gain whatever the gain field holds
  // second stage: the gain applies only while the stage is enabled
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      second_stage_enable_b_o <= 1'b0;
      second_stage_gain_b_o <= 3'h0;
      stage_gain_tenth_db_o <= 7'h00;
      gain_reserved_o <= 1'b0;
    end else if (ce_i) begin
      second_stage_enable_b_o <= rx_gain_r[S2EN_BIT];
      second_stage_gain_b_o <= gain_code;
      gain_reserved_o <= gain_code > GAIN_MAX_CODE;
      stage_gain_tenth_db_o <= rx_gain_r[S2EN_BIT] ?
        gain_tdb(gain_code) : 7'h00;
    end
  end

  // every capacitor code is legal and simply sums, so no reserved
  // flag exists for it
  // feedback network values
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      feedback_cap_select_o <= 5'h00;
      feedback_cap_pf_o <= CAP_BASE_PF;
      feedback_res_select_o <= 3'h0;
      feedback_res_kohm_o <= 10'h1F4;
      feedback_res_none_o <= 1'b0;
    end else if (ce_i) begin
      feedback_cap_select_o <= cap_code;
      feedback_cap_pf_o <= cap_pf(cap_code);
      feedback_res_select_o <= res_code;
      feedback_res_kohm_o <= res_kohm(res_code);
      feedback_res_none_o <= res_code == RES_NONE_CODE;
    end
  end

  // ==========================================================
  // transmit drive settings
  logic [1:0] rng;
  logic [6:0] fs;
  logic [7:0] code_a;
  logic [7:0] code_b;
  assign rng = led_ctrl_r[RANGE_LSB +: 2];
  assign code_a = led_ctrl_r[DRVA_LSB +: 8];
  assign code_b = led_ctrl_r[DRVB_LSB +: 8];
  assign fs = fullscale(rng, tx_ref_i);

  // the reference level is a live input, not a stored bit, so full
  // scale follows it one clock later even with the range unchanged
  // range state: off wins over any reference level
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_fullscale_range_o <= 2'h0;
      drive_alt_scale_o <= 1'b0;
      tx_off_o <= 1'b0;
      fullscale_ma_o <= FS_0_MA;
    end else if (ce_i) begin
      drive_fullscale_range_o <= rng;
      drive_alt_scale_o <= rng == RANGE_ALT;
      tx_off_o <= rng == RANGE_OFF;
      fullscale_ma_o <= fs;
    end
  end

  // the undivided product costs eight output bits but never rounds
  // drive currents carried as 256 times mA to keep full precision
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_current_a_o <= 8'h00;
      drive_current_b_o <= 8'h00;
      drive_a_x256_ma_o <= 15'h0000;
      drive_b_x256_ma_o <= 15'h0000;
    end else if (ce_i) begin
      drive_current_a_o <= code_a;
      drive_current_b_o <= code_b;
      drive_a_x256_ma_o <= scale(code_a, fs);
      drive_b_x256_ma_o <= scale(code_b, fs);
    end
  end

endmodule

// [tb/ofg_host_model.sv]
// host side model: drives serial frames into the register port
`timescale 1ns/1ns
module ofg_host_model (
  input wire logic clk_i,
  input wire logic miso_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic mosi_o
);
  logic busy_r = 1'b0;
  logic bit_r = 1'b0;
  logic idle_r = 1'b0;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
  end
  // a released data line keeps no value: it toggles every cycle
  always @(negedge clk_i) begin
    idle_r <= ~idle_r;
  end
  assign mosi_o = busy_r ? bit_r : idle_r;
  // nb bits msb first; sclk low 3 clocks, high 2, idle low between frames
  task automatic xfer(input logic [31:0] fr, input int nb,
                      output logic [23:0] q);
    logic [31:0] sh;
    sh = 32'h00000000;
    busy_r = 1'b1;
    cs_n_o = 1'b0;
    for (int i = 31; i > 31 - nb; i--) begin
      bit_r = fr[i];
      repeat (3) @(negedge clk_i);
      sh = {sh[30:0], miso_i};
      sclk_o = 1'b1;
      repeat (2) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    repeat (2) @(negedge clk_i);
    cs_n_o = 1'b1;
    busy_r = 1'b0;
    repeat (3) @(negedge clk_i);
    q = sh[23:0];
  endtask
endmodule

// [tb/ofg_regs_chk.sv]
// decoding and port timing assertions for the register block
`timescale 1ns/1ns
module ofg_regs_chk
  import ofg_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic spi_cs_n_i,
  input wire logic [1:0] tx_ref_i,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe_n_o,
  input wire logic [3:0] ambient_cancel_current_code_o,
  input wire logic [3:0] ambient_ua_o,
  input wire logic ambient_reserved_o,
  input wire logic second_stage_enable_b_o,
  input wire logic [2:0] second_stage_gain_b_o,
  input wire logic [6:0] stage_gain_tenth_db_o,
  input wire logic gain_reserved_o,
  input wire logic [4:0] feedback_cap_select_o,
  input wire logic [7:0] feedback_cap_pf_o,
  input wire logic [2:0] feedback_res_select_o,
  input wire logic [9:0] feedback_res_kohm_o,
  input wire logic feedback_res_none_o,
  input wire logic [1:0] drive_fullscale_range_o,
  input wire logic drive_alt_scale_o,
  input wire logic tx_off_o,
  input wire logic [6:0] fullscale_ma_o,
  input wire logic [7:0] drive_current_a_o,
  input wire logic [7:0] drive_current_b_o,
  input wire logic [14:0] drive_a_x256_ma_o,
  input wire logic [14:0] drive_b_x256_ma_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [1:0] warm_r;
  wire warm = warm_r == 2'h3 && ce_i;
  // settle guard: outputs only judged a few cycles after reset
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      warm_r <= 2'h0;
    end else if (warm_r != 2'h3) begin
      warm_r <= warm_r + 2'h1;
    end
  end
  // ==========================================================
  // expected decodes
  function automatic logic [6:0] gain_f(logic en, logic [2:0] g);
    logic [6:0] t [5] = '{7'h00, 7'h23, 7'h3C, 7'h5F, 7'h78};
    return (en && g <= 3'h4) ? t[g] : 7'h00;
  endfunction
  function automatic logic [9:0] res_f(logic [2:0] s);
    logic [9:0] t [8] = '{10'h1F4, 10'h0FA, 10'h064, 10'h032,
                          10'h019, 10'h00A, 10'h3E8, 10'h000};
    return t[s];
  endfunction
  function automatic logic [7:0] cap_f(logic [4:0] s);
    return 8'h05 + (s[0] ? 8'h05 : 8'h00) + (s[1] ? 8'h0F : 8'h00) +
      (s[2] ? 8'h19 : 8'h00) + (s[3] ? 8'h32 : 8'h00) +
      (s[4] ? 8'h96 : 8'h00);
  endfunction
  // reference order 0.25, 0.5, 1.0, 0.75 V
  function automatic logic [6:0] fs_f(logic [1:0] r, logic [1:0] v);
    logic [6:0] alt [4] = '{7'h19, 7'h32, 7'h64, 7'h4B};
    logic [6:0] nrm [4] = '{7'h32, 7'h64, 7'h00, 7'h00};
    return r == 2'h3 ? 7'h00 : r == 2'h1 ? alt[v] : nrm[v];
  endfunction
  // ==========================================================
  // assertions: decodes are judged once their inputs held two cycles
  a_ambient_map: assert property (
    (warm && $stable(ambient_cancel_current_code_o))[*2] |->
    ambient_ua_o == (ambient_cancel_current_code_o <= 4'hA ?
    ambient_cancel_current_code_o : 4'h0) &&
    ambient_reserved_o == (ambient_cancel_current_code_o > 4'hA))
    else $error("ambient decode wrong");
  a_gain_apply: assert property (
    (warm && $stable({second_stage_enable_b_o, second_stage_gain_b_o}))[*2]
    |-> stage_gain_tenth_db_o == gain_f(second_stage_enable_b_o,
    second_stage_gain_b_o) &&
    gain_reserved_o == (second_stage_gain_b_o > 3'h4))
    else $error("stage gain decode wrong");
  a_cap_sum: assert property (
    (warm && $stable(feedback_cap_select_o))[*2] |->
    feedback_cap_pf_o == cap_f(feedback_cap_select_o))
    else $error("capacitance sum wrong");
  a_res_map: assert property (
    (warm && $stable(feedback_res_select_o))[*2] |->
    feedback_res_kohm_o == res_f(feedback_res_select_o) &&
    feedback_res_none_o == (feedback_res_select_o == 3'h7))
    else $error("resistor decode wrong");
  a_range_decode: assert property (
    (warm && $stable(drive_fullscale_range_o))[*2] |->
    tx_off_o == (drive_fullscale_range_o == 2'h3) &&
    drive_alt_scale_o == (drive_fullscale_range_o == 2'h1))
    else $error("range flags wrong");
  a_fullscale_pick: assert property (
    (warm && $stable({drive_fullscale_range_o, tx_ref_i}))[*2] |->
    fullscale_ma_o == fs_f(drive_fullscale_range_o, tx_ref_i))
    else $error("full-scale current wrong");
  a_drive_a_scale: assert property (
    (warm && $stable({drive_current_a_o, fullscale_ma_o}))[*2] |->
    drive_a_x256_ma_o == 15'(drive_current_a_o) * 15'(fullscale_ma_o))
    else $error("first drive product wrong");
  a_drive_b_scale: assert property (
    (warm && $stable({drive_current_b_o, fullscale_ma_o}))[*2] |->
    drive_b_x256_ma_o == 15'(drive_current_b_o) * 15'(fullscale_ma_o))
    else $error("second drive product wrong");
  a_oe_follow: assert property (warm |->
    spi_miso_oe_n_o == $past(spi_cs_n_i))
    else $error("data out enable not following select");
  a_miso_idle: assert property (spi_cs_n_i[*2] |=> !spi_miso_o)
    else $error("data out not quiet between frames");
  // a low clock enable must hold full scale, the first drive product and the data out enable
  a_ce_freeze: assert property (!ce_i |=>
    $stable({fullscale_ma_o, drive_a_x256_ma_o, spi_miso_oe_n_o}))
    else $error("outputs moved while clock enable low");
  c_read_bit: cover property (!spi_cs_n_i && spi_miso_o);
  c_tx_off: cover property (tx_off_o);
  c_gain_rsvd: cover property (gain_reserved_o);
endmodule

// [tb/ofg_regs_bench.sv]
// self-checking bench for the gain and drive register block
`timescale 1ns/1ns
module ofg_regs_bench;
  import ofg_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic [1:0] tx_ref_i = 2'h0;
  logic spi_cs_n_i, spi_sclk_i, spi_mosi_i, spi_miso_o, spi_miso_oe_n_o;
  logic [3:0] ambient_cancel_current_code_o, ambient_ua_o;
  logic ambient_reserved_o, second_stage_enable_b_o, gain_reserved_o;
  logic [2:0] second_stage_gain_b_o, feedback_res_select_o;
  logic [6:0] stage_gain_tenth_db_o, fullscale_ma_o;
  logic [4:0] feedback_cap_select_o;
  logic [7:0] feedback_cap_pf_o, drive_current_a_o, drive_current_b_o;
  logic [9:0] feedback_res_kohm_o;
  logic feedback_res_none_o, drive_alt_scale_o, tx_off_o;
  logic [1:0] drive_fullscale_range_o;
  logic [14:0] drive_a_x256_ma_o, drive_b_x256_ma_o;
  int err_count = 0;
  int comparisons = 0;
  int seed = 32'hA57A5493;
  logic [23:0] q, rx, led;
  // 10 MHz clock
  always #50 core_clk_i = ~core_clk_i;
  ofg_regs dut_u (.*);
  ofg_host_model host_u (.clk_i(core_clk_i), .miso_i(spi_miso_o),
    .cs_n_o(spi_cs_n_i), .sclk_o(spi_sclk_i), .mosi_o(spi_mosi_i));
  // ==========================================================
  // shared tasks
  task automatic chk(string nm, logic [23:0] ex, logic [23:0] got);
    comparisons++;
    if (got !== ex) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [23:0] d, int nb = 32);
    host_u.xfer({a, d}, nb, q);
    repeat (3) @(negedge core_clk_i);
  endtask
  // read mode is left again afterwards so later writes land
  task automatic rdreg(logic [7:0] a, logic [23:0] ex, string nm);
    wr(ADDR_READ_CTRL, 24'h000001);
    host_u.xfer({a, 24'h000000}, 32, q);
    chk(nm, ex, q);
    wr(ADDR_READ_CTRL, 24'h000000);
  endtask
  task automatic chk_out();
    chk("amb", 24'(rx[19:16]), 24'(ambient_cancel_current_code_o));
    chk("s2en", 24'(rx[14]), 24'(second_stage_enable_b_o));
    chk("gain", 24'(rx[10:8]), 24'(second_stage_gain_b_o));
    chk("cap", 24'(rx[7:3]), 24'(feedback_cap_select_o));
    chk("res", 24'(rx[2:0]), 24'(feedback_res_select_o));
    chk("range", 24'(led[17:16]), 24'(drive_fullscale_range_o));
    chk("drv_a", 24'(led[15:8]), 24'(drive_current_a_o));
    chk("drv_b", 24'(led[7:0]), 24'(drive_current_b_o));
  endtask
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    rx = RST_RX_GAIN;
    led = RST_LED_CTRL;
    chk_out();
    chk("cap_pf", 24'h000005, 24'(feedback_cap_pf_o));
    rdreg(ADDR_RX_GAIN, 24'h000000, "rx_rd");
    rdreg(ADDR_LED_CTRL, 24'h000000, "led_rd");
    // every code of the ambient, gain, resistor and range fields, single capacitor bits in turn
    for (int i = 0; i < 16; i++) begin
      rx = {4'h0, 4'(i), 1'b0, i[0], 3'h0, 3'(i), 5'(1 << (i % 5)), 3'(i)};
      led = {6'h00, 2'(i), 8'(i * 17), 8'hFF - 8'(i)};
      tx_ref_i = 2'(i >> 2);
      wr(ADDR_RX_GAIN, rx);
      wr(ADDR_LED_CTRL, led);
      chk_out();
    end
    // random legal settings, reserved bits kept zero
    repeat (20) begin
      rx = 24'($random(seed)) & RX_GAIN_WMASK;
      led = 24'($random(seed)) & LED_CTRL_WMASK;
      tx_ref_i = 2'($random(seed));
      wr(ADDR_RX_GAIN, rx);
      wr(ADDR_LED_CTRL, led);
      chk_out();
    end
    rx = 24'h000078;
    wr(ADDR_RX_GAIN, rx);
    chk("cf_sum", 24'h000064, 24'(feedback_cap_pf_o));
    // reserved bits written as ones must read back as zero
    wr(ADDR_RX_GAIN, 24'hFFFFFF);
    rdreg(ADDR_RX_GAIN, 24'h0F47FF, "rx_mask");
    wr(ADDR_LED_CTRL, 24'hFFFFFF);
    rdreg(ADDR_LED_CTRL, 24'h03FFFF, "led_mask");
    chk("tx_off", 24'h000001, 24'(tx_off_o));
    // a short frame is dropped; writes are refused in read mode
    wr(ADDR_LED_CTRL, 24'h01A05F, 20);
    wr(ADDR_READ_CTRL, 24'h000001);
    wr(ADDR_LED_CTRL, 24'h01A05F);
    host_u.xfer({8'h30, 24'h000000}, 32, q);
    chk("unmapped", 24'h000000, q);
    host_u.xfer({ADDR_LED_CTRL, 24'h000000}, 32, q);
    chk("led_hold", 24'h03FFFF, q);
    wr(ADDR_READ_CTRL, 24'h000000);
    rx = 24'h0F47FF;
    led = 24'h01A05F;
    wr(ADDR_LED_CTRL, led);
    chk_out();
    chk("alt", 24'h000001, 24'(drive_alt_scale_o));
    // clock enable low: a new reference level must wait for it
    tx_ref_i = TXREF_0P5;
    repeat (3) @(negedge core_clk_i);
    ce_i = 1'b0;
    tx_ref_i = TXREF_1P0;
    repeat (4) @(negedge core_clk_i);
    chk("ce_hold", 24'h000032, 24'(fullscale_ma_o));
    ce_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    chk("ce_run", 24'h000064, 24'(fullscale_ma_o));
    summarize();
  end
  // watchdog: the whole sequence needs about 16000 cycles
  initial begin
    repeat (60000) @(posedge core_clk_i);
    err_count++;
    summarize();
  end
endmodule
bind ofg_regs ofg_regs_chk chk_u (.*);
